// ---- src/cvf_top.sv ----
// cell overvolt / undervolt fault logic with apb registers and interrupt
// assumes external per-cell comparators against the levels driven out here
//
// Our own choice: register access over APB.
module cvf_top import cvf_pkg::*; #(
  parameter int P_TICK_CYCLES = TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [9:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NCELL-1:0] i_cell_above_ov_trip,
  input wire logic [NCELL-1:0] i_cell_below_ov_recover,
  input wire logic [NCELL-1:0] i_cell_below_uv_trip,
  input wire logic [NCELL-1:0] i_cell_above_uv_recover,
  input wire logic i_charger_detect,
  input wire logic i_load_removed,
  input wire logic i_thermistor_line,
  output logic o_thermistor_line_out,
  output logic o_thermistor_line_oe_n,
  output logic [12:0] o_ov_trip_mv,
  output logic [12:0] o_ov_recover_mv,
  output logic [11:0] o_uv_trip_mv,
  output logic [11:0] o_uv_recover_mv,
  output logic o_ov_fault,
  output logic o_uv_fault,
  output logic o_charge_switch_en,
  output logic o_shutdown_req,
  output logic o_irq
);
  localparam int SYNC_W = 4 * NCELL + 3;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_TICK_CYCLES - 1);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [7:0] ov1;
    logic [7:0] ov2;
    logic [7:0] uv1;
    logic [7:0] uv2;
    logic ov_fault;
    cvf_uv_state_t uv_state;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic [31:0] prdata;
    logic [12:0] ov_trip;
    logic [12:0] ov_rec;
    logic [11:0] uv_trip;
    logic [11:0] undervolt_recovery_mode;
    logic chg_sw;
    logic therm_oe_n;
    logic irq;
  } cvf_state_t;

  cvf_state_t r;
  cvf_state_t n;

  logic [NCELL-1:0] ov_above;
  logic [NCELL-1:0] ov_below;
  logic [NCELL-1:0] uv_below;
  logic [NCELL-1:0] uv_above;
  logic chg_det;
  logic load_off;
  logic therm_level;
  logic ov_run;
  logic uv_run;
  logic shdn_run;
  logic ov_done;
  logic uv_done;
  logic shdn_done;
  logic [LIM_W-1:0] ov_lim;
  logic [LIM_W-1:0] uv_lim;
  logic [2:0] uv_dly;
  logic map_hit;
  logic acc;

  assign {therm_level, load_off, chg_det, uv_above, uv_below, ov_below, ov_above} = r.s2;

  // ****************************************************************
  // delay timers
  // ****************************************************************
  // R3 delay in ticks
  assign ov_lim = OV_DLY_BASE_TICKS + LIM_W'(OV_DLY_STEP_TICKS * r.ov2[OV2_DLY_LSB +: 3]);
  assign uv_dly = r.uv2[UV2_DLY_LSB +: 3];
  // R11 doubling delay, off means immediate
  assign uv_lim = (uv_dly == UV_DLY_OFF) ? '0 : LIM_W'(UV_DLY_BASE_TICKS << uv_dly);
  // R13 run while any cell high
  assign ov_run = !r.ov_fault && (|ov_above);
  // R14 restart when condition goes
  assign uv_run = (r.uv_state == UV_NORMAL) && (|uv_below);
  // R8 any cell still under recovery
  assign shdn_run = (r.uv_state == UV_FAULT) && r.uv2[UV2_SHDN_BIT] && !(&uv_above);

  cvf_timer u_ov_tmr (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_run(ov_run), .i_tick(r.tick),
    .i_limit(ov_lim), .o_done(ov_done)
  );
  cvf_timer u_uv_tmr (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_run(uv_run), .i_tick(r.tick),
    .i_limit(uv_lim), .o_done(uv_done)
  );
  cvf_timer u_shdn_tmr (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_run(shdn_run), .i_tick(r.tick),
    .i_limit(SHDN_LIMIT_TICKS), .o_done(shdn_done)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  always_comb begin
    case (i_paddr)
      ADDR_OV_CONF1, ADDR_OV_CONF2, ADDR_UV_CONF1, ADDR_UV_CONF2,
      ADDR_STATUS, ADDR_MASK, ADDR_STATE: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  end
  assign acc = i_psel && i_penable;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [ST_W-1:0] ev;
    logic [12:0] uv_sum;
    ev = '0;
    uv_sum = '0;
    n = r;
    n.s1 = {i_thermistor_line, i_load_removed, i_charger_detect, i_cell_above_uv_recover,
            i_cell_below_uv_trip, i_cell_below_ov_recover, i_cell_above_ov_trip};
    n.s2 = r.s1;
    if (r.tick_cnt == TICK_LAST) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = r.tick_cnt + 1'b1;
      n.tick = 1'b0;
    end
    // R12 overvolt trip level
    n.ov_trip = OV_TRIP_BASE_MV + 13'(OV_TRIP_STEP_MV * r.ov1[5:0]);
    // R2 overvolt hysteresis
    n.ov_rec = n.ov_trip - cvf_ov_hyst_mv(r.ov2[OV2_HYST_LSB +: 3]);
    // R5 undervolt trip level
    n.uv_trip = UV_TRIP_BASE_MV + 12'(UV_TRIP_STEP_MV * r.uv1[UV1_TRIP_LSB +: 4]);
    // R9 undervolt hysteresis
    uv_sum = {1'b0, n.uv_trip} +
             13'(UV_HYST_STEP_MV * ({1'b0, r.uv2[UV2_HYST_LSB +: 2]} + 3'd1));
    // R10 recovery cap, sum one bit wider so high trip plus hysteresis cannot wrap
    n.undervolt_recovery_mode = (uv_sum > {1'b0, UV_RCV_MAX_MV}) ? UV_RCV_MAX_MV : uv_sum[11:0];
    // R4 inhibit hysteresis
    if (r.uv1[UV1_INH_BIT]) begin
      n.undervolt_recovery_mode = n.uv_trip;
    end
    // R13 overvolt entry and exit
    if (!r.ov_fault && ov_done) begin
      n.ov_fault = 1'b1;
      ev[ST_OV_ON] = 1'b1;
    end else if (r.ov_fault && (&ov_below)) begin
      n.ov_fault = 1'b0;
      ev[ST_OV_OFF] = 1'b1;
    end
    case (r.uv_state)
      UV_NORMAL: begin
        // R14 fault after full delay
        if (uv_done) begin
          n.uv_state = UV_FAULT;
          ev[ST_UV_ON] = 1'b1;
        end
      end
      UV_FAULT: begin
        // R6 R7 recovery conditions
        if ((&uv_above) && (!r.uv2[UV2_REC_BIT] || load_off)) begin
          n.uv_state = UV_NORMAL;
          ev[ST_UV_OFF] = 1'b1;
        // R8 timed shutdown
        end else if (shdn_done) begin
          n.uv_state = UV_SHUTDOWN;
          ev[ST_SHDN] = 1'b1;
        end
      end
      UV_SHUTDOWN: begin
        n.uv_state = UV_SHUTDOWN;
      end
      default: begin
        n.uv_state = UV_NORMAL;
      end
    endcase
    // R6 charger re-enables charging in recovery mode 0
    n.chg_sw = !n.ov_fault && ((n.uv_state == UV_NORMAL) ||
               ((n.uv_state == UV_FAULT) && !r.uv2[UV2_REC_BIT] && chg_det));
    // R1 pull thermistor line during overvolt
    n.therm_oe_n = !(n.ov_fault && r.ov2[OV2_CHG_SIG_BIT]);
    // status read clears only the bits it returned, so a later event is kept; new events win
    n.stat = r.stat | ev;
    if (acc && !i_pwrite && (i_paddr == ADDR_STATUS)) begin
      n.stat = (r.stat & ~r.prdata[ST_W-1:0]) | ev;
    end
    if (acc && i_pwrite) begin
      case (i_paddr)
        ADDR_OV_CONF1: n.ov1 = i_pwdata[7:0] & OV1_WMASK;
        ADDR_OV_CONF2: n.ov2 = i_pwdata[7:0] & OV2_WMASK;
        ADDR_UV_CONF1: n.uv1 = i_pwdata[7:0] & UV1_WMASK;
        ADDR_UV_CONF2: n.uv2 = i_pwdata[7:0] & UV2_WMASK;
        ADDR_MASK: n.mask = i_pwdata[ST_W-1:0];
        default: n.mask = r.mask;
      endcase
    end
    // read data is prepared in the setup phase
    if (i_psel && !i_penable) begin
      case (i_paddr)
        ADDR_OV_CONF1: n.prdata = {24'h0, r.ov1};
        ADDR_OV_CONF2: n.prdata = {24'h0, r.ov2};
        ADDR_UV_CONF1: n.prdata = {24'h0, r.uv1};
        ADDR_UV_CONF2: n.prdata = {24'h0, r.uv2};
        ADDR_STATUS: n.prdata = {27'h0, r.stat};
        ADDR_MASK: n.prdata = {27'h0, r.mask};
        ADDR_STATE: n.prdata = {27'h0, therm_level, r.chg_sw, r.uv_state == UV_SHUTDOWN,
                                r.uv_state != UV_NORMAL, r.ov_fault};
        default: n.prdata = 32'h0;
      endcase
    end
    n.irq = |(n.stat & r.mask);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.ov1 <= OV1_RESET;
      r.ov2 <= OV2_RESET;
      r.uv1 <= UV1_RESET;
      r.uv2 <= UV2_RESET;
      r.uv_state <= UV_NORMAL;
      r.chg_sw <= 1'b1;
      r.therm_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !map_hit;
  assign o_prdata = r.prdata;
  assign o_thermistor_line_out = 1'b0;
  assign o_thermistor_line_oe_n = r.therm_oe_n;
  assign o_ov_trip_mv = r.ov_trip;
  assign o_ov_recover_mv = r.ov_rec;
  assign o_uv_trip_mv = r.uv_trip;
  assign o_uv_recover_mv = r.undervolt_recovery_mode;
  assign o_ov_fault = r.ov_fault;
  assign o_uv_fault = r.uv_state != UV_NORMAL;
  assign o_charge_switch_en = r.chg_sw;
  assign o_shutdown_req = r.uv_state == UV_SHUTDOWN;
  assign o_irq = r.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_ts_pull_low: assert property ( // R1
    (o_ov_fault && $past(r.ov2[OV2_CHG_SIG_BIT])) |-> !o_thermistor_line_oe_n)
    else $error("thermistor line not pulled during overvolt");
  chk_ts_release: assert property ( // R1
    !o_ov_fault |-> o_thermistor_line_oe_n)
    else $error("thermistor line pulled outside overvolt");
  chk_ov_hyst_zero: assert property ( // R2
    (r.ov2[OV2_HYST_LSB +: 3] == 3'h7) [*2] |-> (o_ov_recover_mv == o_ov_trip_mv))
    else $error("overvolt hysteresis code 7 not zero");
  chk_ov_trip_top: assert property ( // R12
    (r.ov1[5:0] == 6'h3f) [*2] |-> (o_ov_trip_mv == 13'd4375))
    else $error("overvolt trip top code wrong");
  chk_ov_delay_done: assert property ( // R13
    $rose(r.ov_fault) |-> $past(ov_done) && $past(|ov_above))
    else $error("overvolt fault without full delay");
  chk_uv_trip_top: assert property ( // R5
    (r.uv1[3:0] == 4'hf && r.uv1[UV1_INH_BIT]) [*2] |-> (o_uv_recover_mv == 12'd2900))
    else $error("undervolt trip top code wrong");
  chk_undervolt_recovery_mode_cap: assert property ( // R10
    o_uv_recover_mv <= UV_RCV_MAX_MV)
    else $error("undervolt recovery above cap");
  chk_uv_hyst_max: assert property ( // R9
    (r.uv1 == 8'h00 && r.uv2[UV2_HYST_LSB +: 2] == 2'h3) [*2] |-> (o_uv_recover_mv == 12'd3000))
    else $error("undervolt hysteresis decode wrong");
  chk_uv_load_gate: assert property ( // R7
    ($past(r.uv_state) == UV_FAULT && r.uv_state == UV_NORMAL && $past(r.uv2[UV2_REC_BIT]))
    |-> $past(load_off))
    else $error("undervolt recovery without load removal");
  chk_uv_delay_run: assert property ( // R14
    $rose(o_uv_fault) |-> $past(uv_run) && $past(|uv_below))
    else $error("undervolt fault without delay");
  chk_uv_chg_enable: assert property ( // R6
    (r.uv_state == UV_FAULT && !r.uv2[UV2_REC_BIT] && chg_det && !r.ov_fault && !shdn_done
     && !(&uv_above) && !ov_done) |=> o_charge_switch_en)
    else $error("charger did not enable charge switch");
  chk_shdn_disabled: assert property ( // R8
    (!r.uv2[UV2_SHDN_BIT] && r.uv_state != UV_SHUTDOWN) |=> !o_shutdown_req)
    else $error("shutdown entered while disabled");

  cov_ov_fault: cover property ($rose(r.ov_fault));
  cov_uv_fault: cover property ($rose(o_uv_fault));
  cov_shutdown: cover property ($rose(o_shutdown_req));
  cov_irq: cover property ($rose(o_irq));
endmodule : cvf_top

// ---- src/cvf_pkg.sv ----
// constants, field layout and types of the cell voltage fault block
// assumes a 25 MHz clock and an apb master with 32-bit data
// ****************************************************************
// Overview of operation
// R1: with the charger-signal bit set the thermistor line is pulled low during an overvolt fault.
// R2: the overvolt hysteresis code maps 000..111 to 300,250,200,150,100,50,25,0 mV.
// R3: the overvolt delay code maps 000..111 to 0.50 s..2.25 s in 0.25 s steps.
// R4: with hysteresis inhibit set the undervolt recovery level equals the trip level.
// R5: the undervolt trip code maps 0000..1111 to 1.4 V..2.9 V in 0.1 V steps.
// R6: in recovery mode 0 the fault ends when all cells exceed the recovery level, charger enables charging.
// R7: in recovery mode 1 the fault ends only when all cells recover and the load is removed.
// R8: with shutdown enabled a cell below recovery level for over 8 s in undervolt fault forces shutdown.
// R9: the undervolt hysteresis code maps 00..11 to 0.4, 0.8, 1.2 and 1.6 V.
// R10: the undervolt recovery level is trip plus hysteresis, capped at 3.5 V.
// R11: the undervolt delay code maps 000..110 to 0.5..32 s doubling, and 111 means no delay.
// R12: the overvolt trip code maps 0x00..0x3f to 2.800 V..4.375 V in 25 mV steps.
// R13: an overvolt fault needs a cell above trip for the full delay and clears when all are below recovery.
// R14: an undervolt fault needs a cell below trip for the full delay, and the timer restarts when it clears.
// ****************************************************************
package cvf_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 250;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int NCELL = 8;
  localparam int TICK_W = 23;
  localparam int LIM_W = 8;

  // register indices; the bus address is four times the index
  localparam logic [7:0] IDX_OV_CONF1 = 8'h02;
  localparam logic [7:0] IDX_OV_CONF2 = 8'h03;
  localparam logic [7:0] IDX_UV_CONF1 = 8'h04;
  localparam logic [7:0] IDX_UV_CONF2 = 8'h05;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_MASK = 8'h11;
  localparam logic [7:0] IDX_STATE = 8'h12;
  localparam logic [9:0] ADDR_OV_CONF1 = {IDX_OV_CONF1, 2'b00};
  localparam logic [9:0] ADDR_OV_CONF2 = {IDX_OV_CONF2, 2'b00};
  localparam logic [9:0] ADDR_UV_CONF1 = {IDX_UV_CONF1, 2'b00};
  localparam logic [9:0] ADDR_UV_CONF2 = {IDX_UV_CONF2, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [9:0] ADDR_STATE = {IDX_STATE, 2'b00};

  // writable bits of each config register, reserved bits read zero
  localparam logic [7:0] OV1_WMASK = 8'h3f;
  localparam logic [7:0] OV2_WMASK = 8'hf7;
  localparam logic [7:0] UV1_WMASK = 8'h8f;
  localparam logic [7:0] UV2_WMASK = 8'hf7;
  localparam logic [7:0] OV1_RESET = 8'h00;
  localparam logic [7:0] OV2_RESET = 8'h00;
  localparam logic [7:0] UV1_RESET = 8'h00;
  localparam logic [7:0] UV2_RESET = 8'h00;

  localparam int OV2_CHG_SIG_BIT = 7;
  localparam int OV2_HYST_LSB = 4;
  localparam int OV2_DLY_LSB = 0;
  localparam int UV1_INH_BIT = 7;
  localparam int UV1_TRIP_LSB = 0;
  localparam int UV2_REC_BIT = 7;
  localparam int UV2_SHDN_BIT = 6;
  localparam int UV2_HYST_LSB = 4;
  localparam int UV2_DLY_LSB = 0;

  // levels in millivolts
  localparam logic [12:0] OV_TRIP_BASE_MV = 13'd2800;
  localparam logic [12:0] OV_TRIP_STEP_MV = 13'd25;
  localparam logic [11:0] UV_TRIP_BASE_MV = 12'd1400;
  localparam logic [11:0] UV_TRIP_STEP_MV = 12'd100;
  localparam logic [11:0] UV_HYST_STEP_MV = 12'd400;
  localparam logic [11:0] UV_RCV_MAX_MV = 12'd3500;

  // delays in milliseconds, converted to 250 ms ticks
  localparam int OV_DLY_BASE_MS = 500;
  localparam int OV_DLY_STEP_MS = 250;
  localparam int UV_DLY_BASE_MS = 500;
  localparam int SHDN_MS = 8000;
  localparam logic [LIM_W-1:0] OV_DLY_BASE_TICKS = LIM_W'(OV_DLY_BASE_MS / TICK_MS);
  localparam logic [LIM_W-1:0] OV_DLY_STEP_TICKS = LIM_W'(OV_DLY_STEP_MS / TICK_MS);
  localparam logic [LIM_W-1:0] UV_DLY_BASE_TICKS = LIM_W'(UV_DLY_BASE_MS / TICK_MS);
  localparam logic [LIM_W-1:0] SHDN_LIMIT_TICKS = LIM_W'(SHDN_MS / TICK_MS + 1);
  localparam logic [2:0] UV_DLY_OFF = 3'h7;

  // sticky event bits of the status and mask registers
  localparam int ST_OV_ON = 0;
  localparam int ST_OV_OFF = 1;
  localparam int ST_UV_ON = 2;
  localparam int ST_UV_OFF = 3;
  localparam int ST_SHDN = 4;
  localparam int ST_W = 5;

  typedef enum logic [1:0] {UV_NORMAL, UV_FAULT, UV_SHUTDOWN} cvf_uv_state_t;

  function automatic logic [12:0] cvf_ov_hyst_mv(input logic [2:0] code);
    case (code)
      3'h0: return 13'd300;
      3'h1: return 13'd250;
      3'h2: return 13'd200;
      3'h3: return 13'd150;
      3'h4: return 13'd100;
      3'h5: return 13'd50;
      3'h6: return 13'd25;
      default: return 13'd0;
    endcase
  endfunction : cvf_ov_hyst_mv
endpackage : cvf_pkg

// ---- src/cvf_timer.sv ----
// tick counter that reports when a condition has lasted a given number of ticks
// assumes a one-cycle tick pulse from the same clock domain
module cvf_timer import cvf_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [LIM_W-1:0] i_limit,
  output logic o_done
);
  typedef struct packed {
    logic [LIM_W-1:0] cnt;
  } cvf_tmr_t;

  cvf_tmr_t r;
  cvf_tmr_t n;

  // count saturates; dropping run restarts from zero
  always_comb begin
    n = r;
    if (!i_run) begin
      n.cnt = '0;
    end else if (i_tick && (r.cnt != '1)) begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_done = i_run && (r.cnt >= i_limit);
endmodule : cvf_timer

// ---- verification/testbench.sv ----
// self-checking bench for the cell voltage fault block over apb
// assumes cvf_pkg and the design files compiled first; ticks shortened to 10 clocks
module testbench import cvf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  localparam int T = 10;
  logic clk, rst_n, psel, pen, pwr, serr, chg, load, therm;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, th_out, th_oe_n, ov_f, uv_f, chg_en, shdn, irq;
  logic [7:0] ov_hi, ov_lo, uv_lo, uv_hi;
  logic [12:0] ov_trip, ov_rec;
  logic [11:0] uv_trip, undervolt_recovery_mode;
  int error_cnt, num_checks, i, j, d, t, e;
  int ov_hys_mv[8] = '{300, 250, 200, 150, 100, 50, 25, 0};

  cvf_top #(.P_TICK_CYCLES(T)) u_dut (
    .i_clk(clk), .i_resetn(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_cell_above_ov_trip(ov_hi), .i_cell_below_ov_recover(ov_lo),
    .i_cell_below_uv_trip(uv_lo), .i_cell_above_uv_recover(uv_hi),
    .i_charger_detect(chg), .i_load_removed(load), .i_thermistor_line(therm),
    .o_thermistor_line_out(th_out), .o_thermistor_line_oe_n(th_oe_n),
    .o_ov_trip_mv(ov_trip), .o_ov_recover_mv(ov_rec), .o_uv_trip_mv(uv_trip),
    .o_uv_recover_mv(undervolt_recovery_mode), .o_ov_fault(ov_f), .o_uv_fault(uv_f),
    .o_charge_switch_en(chg_en), .o_shutdown_req(shdn), .o_irq(irq)
  );
  // open-drain thermistor line with pull-up: low only while the design pulls it
  assign therm = th_oe_n ? 1'b1 : th_out;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; read data and error taken at the edge that sees pready
  task apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: no bus answer", $time);
      results();
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task wr(input logic [9:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr

  task rd(input logic [9:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask : rd

  task settle;
    repeat (4) @(posedge clk);
  endtask : settle

  function automatic logic flag(input int w);
    case (w)
      0: return ov_f;
      1: return uv_f;
      default: return shdn;
    endcase
  endfunction : flag

  // waits for a fault flag to reach v, checks it took at least lo cycles
  task wait_flag(input int w, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (flag(w) !== v) begin
      @(posedge clk);
      n++;
      if (n > hi) begin
        error_cnt++;
        $display("unexpected at %0t: flag %0d late", $time, w);
        results();
      end
    end
    check({31'h0, n >= lo}, 32'h1);
  endtask : wait_flag
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {psel, pen, pwr, chg, load} = 5'h00;
    paddr = 10'h000;
    pwdata = 32'h0;
    {ov_hi, ov_lo, uv_lo, uv_hi} = 32'h00ff00ff;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    check(ov_trip, 32'd2800);
    check(ov_rec, 32'd2500);
    check(uv_trip, 32'd1400);
    check(undervolt_recovery_mode, 32'd1800);
    check({th_out, th_oe_n}, 32'h1);
    rd(ADDR_UV_CONF2, 32'h0);
    wr(ADDR_OV_CONF2, 32'hff);
    rd(ADDR_OV_CONF2, 32'hf7);
    wr(ADDR_UV_CONF1, 32'hff);
    rd(ADDR_UV_CONF1, 32'h8f);
    wr(ADDR_UV_CONF2, 32'hff);
    rd(ADDR_UV_CONF2, 32'hf7);
    apb(1'b0, 10'h3fc, 32'h0);
    check({serr, rdata[30:0]}, 32'h80000000);
    for (i = 0; i < 64; i++) begin
      wr(ADDR_OV_CONF1, 32'(i));
      settle;
      check(ov_trip, 32'(2800 + 25 * i));
    end
    rd(ADDR_OV_CONF1, 32'h3f);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_OV_CONF2, 32'(i << 4));
      settle;
      check(ov_rec, 32'(4375 - ov_hys_mv[i]));
    end
    for (i = 0; i < 32; i++) begin
      wr(ADDR_UV_CONF1, 32'(((i >> 4) << 7) | (i & 15)));
      t = 1400 + 100 * (i & 15);
      for (j = 0; j < 4; j++) begin
        wr(ADDR_UV_CONF2, 32'(j << 4));
        settle;
        e = (t + 400 * (j + 1) > 3500) ? 3500 : t + 400 * (j + 1);
        check(uv_trip, 32'(t));
        check(undervolt_recovery_mode, 32'((i >= 16) ? t : e));
      end
    end
    // overvolt trip with and without charger signalling, delay codes 0 and 7
    for (i = 0; i < 2; i++) begin
      d = i * 7;
      wr(ADDR_OV_CONF2, 32'((i == 0 ? 8'h80 : 8'h00) | d));
      wr(ADDR_MASK, i == 0 ? 32'h1f : 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      @(posedge clk);
      ov_hi <= 8'h04;
      ov_lo <= 8'hfb;
      wait_flag(0, 1'b1, (1 + d) * T, (2 + d) * T + 8);
      settle;
      check(th_oe_n, 32'(i));
      check({chg_en, irq}, 32'(i == 0 ? 1 : 0));
      rd(ADDR_STATE, 32'(i == 0 ? 8'h01 : 8'h11));
      rd(ADDR_STATUS, 32'h1);
      settle;
      check(irq, 32'h0);
      ov_hi <= 8'h00;
      repeat (20) @(posedge clk);
      check(ov_f, 32'h1);
      ov_lo <= 8'hff;
      wait_flag(0, 1'b0, 0, 8);
      settle;
      check({th_oe_n, chg_en}, 32'h3);
    end
    // undervolt trip with a timer restart, delay code 2, recovery mode 0
    wr(ADDR_UV_CONF1, 32'h0);
    wr(ADDR_UV_CONF2, 32'h02);
    apb(1'b0, ADDR_STATUS, 32'h0);
    @(posedge clk);
    uv_lo <= 8'h01;
    uv_hi <= 8'hfe;
    repeat (T + 5) @(posedge clk);
    check(uv_f, 32'h0);
    uv_lo <= 8'h00;
    repeat (5) @(posedge clk);
    uv_lo <= 8'h01;
    wait_flag(1, 1'b1, 7 * T, 8 * T + 8);
    chg <= 1'b1;
    settle;
    check(chg_en, 32'h1);
    chg <= 1'b0;
    settle;
    check(chg_en, 32'h0);
    uv_lo <= 8'h00;
    uv_hi <= 8'hff;
    wait_flag(1, 1'b0, 0, 8);
    rd(ADDR_STATUS, 32'hc);
    // recovery mode 1 with delay off
    wr(ADDR_UV_CONF2, 32'h87);
    @(posedge clk);
    uv_lo <= 8'h01;
    uv_hi <= 8'hfe;
    wait_flag(1, 1'b1, 0, 8);
    chg <= 1'b1;
    settle;
    check(chg_en, 32'h0);
    chg <= 1'b0;
    uv_lo <= 8'h00;
    uv_hi <= 8'hff;
    repeat (30) @(posedge clk);
    check(uv_f, 32'h1);
    load <= 1'b1;
    wait_flag(1, 1'b0, 0, 8);
    load <= 1'b0;
    // shutdown disabled, then enabled
    for (i = 0; i < 2; i++) begin
      wr(ADDR_UV_CONF2, i == 0 ? 32'h07 : 32'h47);
      @(posedge clk);
      uv_lo <= 8'h01;
      uv_hi <= 8'hfe;
      wait_flag(1, 1'b1, 0, 8);
      if (i == 0) begin
        repeat (34 * T + 10) @(posedge clk);
        check(shdn, 32'h0);
        uv_lo <= 8'h00;
        uv_hi <= 8'hff;
        wait_flag(1, 1'b0, 0, 8);
      end else begin
        wait_flag(2, 1'b1, 32 * T, 33 * T + 8);
        settle;
        check({uv_f, chg_en}, 32'h2);
      end
    end
    rd(ADDR_STATUS, 32'h1c);
    rd(ADDR_STATE, 32'h16);
    results();
  end
endmodule : testbench
